// ### core/tsic_cfg.svh
// constants for the time signal input control block
// assumes a 200 MHz system clock and a 32-bit AHB-Lite register bus
`ifndef TSIC_CFG_SVH
`define TSIC_CFG_SVH

// register byte offsets (low address byte)
`define TSIC_OFF_CTRL      8'h00
`define TSIC_OFF_HOUR      8'h04
`define TSIC_OFF_STATUS    8'h08
`define TSIC_OFF_BITCNT    8'h0c

// control register fields
`define TSIC_CTRL_PWR_POL  0
`define TSIC_CTRL_INV_LO   1
`define TSIC_CTRL_INV_HI   2
`define TSIC_CTRL_PULL_LO  3
`define TSIC_CTRL_PULL_HI  4
`define TSIC_CTRL_START    5
`define TSIC_CTRL_STOP     6
`define TSIC_CTRL_W        7
`define TSIC_CTRL_RST      7'h01

// mode encodings for inversion and pull-up selects
`define TSIC_MODE_AUTO     2'h0
`define TSIC_INV_NORMAL    2'h1
`define TSIC_INV_INVERT    2'h2
`define TSIC_PULL_ON       2'h1
`define TSIC_PULL_OFF      2'h2

// status register fields
`define TSIC_ST_ANALYSE    0
`define TSIC_ST_INV        1
`define TSIC_ST_PULL       2
`define TSIC_ST_BITVAL     3
`define TSIC_ST_SEEN       4

// daily resync hour
`define TSIC_HOUR_W        5
`define TSIC_HOUR_RST      5'h03

// timing, in milliseconds, converted to cycles of the system clock
`define TSIC_CLK_KHZ       200000
`define TSIC_MIN_MS        50
`define TSIC_SPLIT_MS      150
`define TSIC_MAX_MS        250
`define TSIC_WIN_MS        1000
`define TSIC_MS2CYC(ms)    ((ms) * `TSIC_CLK_KHZ)
`define TSIC_SESSION_WIN   8'hb4

`endif

// ### core/tsic_pkg.sv
// types shared by the time signal input control block
// assumes tsic_cfg.svh holds the numeric constants
package tsic_pkg;

	// session state: receiver off or signal under analysis
	typedef enum logic {TSIC_IDLE, TSIC_ANALYSE} tsic_state_e;

	// width of the timing counters
	typedef logic [31:0] tsic_cnt_t;

endpackage

// ### core/tsic_top.sv
// time signal input control: receiver power, polarity, pull-up, pulse classify
// assumes an AHB-Lite master, pulse input already synchronous to clk_sys_i
//
// Overview of operation
// - receiver enabled only while reception needed
// - enable output polarity set by software
// - input inversion auto-detected, or fixed manually
// - pull-up auto-detected, or forced on/off
// - enable dropped whenever not analysing signal
// - daily resync started at programmed hour
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "tsic_cfg.svh"

module tsic_top
	import tsic_pkg::*;
#(
	parameter tsic_cnt_t MIN_CYC   = 32'(`TSIC_MS2CYC(`TSIC_MIN_MS)),
	parameter tsic_cnt_t SPLIT_CYC = 32'(`TSIC_MS2CYC(`TSIC_SPLIT_MS)),
	parameter tsic_cnt_t MAX_CYC   = 32'(`TSIC_MS2CYC(`TSIC_MAX_MS)),
	parameter tsic_cnt_t WIN_CYC   = 32'(`TSIC_MS2CYC(`TSIC_WIN_MS))
)
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        pulse_in_i,
	input  wire logic [4:0]  cur_hour_i,
	output logic             receiver_power_enable_o,
	output logic             pullup_en_o,
	output logic             bit_strobe_o,
	output logic             bit_value_o
);

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [`TSIC_CTRL_W-1:0] ctrl_q;      // software configuration
	logic [`TSIC_HOUR_W-1:0] hour_q;      // resync hour
	logic                    wr_q;        // write data phase pending
	logic [7:0]              addr_q;      // captured byte offset
	tsic_state_e             state_q;     // session state
	logic                    done_today_q; // resync already run this hour
	logic [7:0]              sess_q;      // windows left in session
	logic                    in_q;        // registered input for edges
	tsic_cnt_t               len_q;       // active pulse length
	tsic_cnt_t               win_q;       // one-second window counter
	tsic_cnt_t               hi_q;        // high cycles in window
	logic                    edge_seen_q; // any edge seen in window
	logic                    auto_inv_q;  // detected inversion
	logic                    auto_pull_q; // pull-up trial state
	logic                    seen_q;      // sticky: a bit was classified
	logic                    last_bit_q;  // value of last bit
	logic [15:0]             bitcnt_q;    // classified bits

	// bus decode
	wire       addr_ph  = hsel_i & htrans_i[1] & hready_i;
	wire       wr_ctrl  = wr_q & (addr_q == `TSIC_OFF_CTRL);
	wire       wr_hour  = wr_q & (addr_q == `TSIC_OFF_HOUR);
	wire       wr_stat  = wr_q & (addr_q == `TSIC_OFF_STATUS);
	wire       sw_start = wr_ctrl & hwdata_i[`TSIC_CTRL_START];
	wire       sw_stop  = wr_ctrl & hwdata_i[`TSIC_CTRL_STOP];
	wire [1:0] inv_mode = ctrl_q[`TSIC_CTRL_INV_HI:`TSIC_CTRL_INV_LO];
	wire [1:0] pull_mode = ctrl_q[`TSIC_CTRL_PULL_HI:`TSIC_CTRL_PULL_LO];
	wire       pwr_pol  = ctrl_q[`TSIC_CTRL_PWR_POL];

	// effective inversion and pull-up selection
	wire inv_use = (inv_mode == `TSIC_MODE_AUTO) ? auto_inv_q :
		(inv_mode == `TSIC_INV_INVERT);
	wire pull_use = (pull_mode == `TSIC_MODE_AUTO) ? auto_pull_q :
		(pull_mode == `TSIC_PULL_ON);

	// session control
	wire analysing = (state_q == TSIC_ANALYSE);
	wire hour_hit  = (cur_hour_i == hour_q);
	wire day_start = hour_hit & ~done_today_q;
	wire win_end   = analysing & (win_q == WIN_CYC - 32'h1);
	wire sess_end  = win_end & (sess_q == 8'h01);

	// pulse classification
	wire act      = in_q ^ inv_use;
	wire act_end  = analysing & act & ~(pulse_in_i ^ inv_use);
	wire len_ok   = (len_q >= MIN_CYC) & (len_q <= MAX_CYC);
	wire bit_ok   = act_end & len_ok;
	wire bit_val  = (len_q >= SPLIT_CYC);

	// read mux
	wire [31:0] status_w = {27'h0, seen_q, last_bit_q, pull_use, inv_use,
		analysing};
	wire [31:0] rd_w = (haddr_i[7:0] == `TSIC_OFF_CTRL)   ? {25'h0, ctrl_q} :
		(haddr_i[7:0] == `TSIC_OFF_HOUR)   ? {27'h0, hour_q} :
		(haddr_i[7:0] == `TSIC_OFF_STATUS) ? status_w :
		(haddr_i[7:0] == `TSIC_OFF_BITCNT) ? {16'h0, bitcnt_q} : 32'h0;

	////////////////////////////////////////////////////////////////////////
	// bus slave: zero wait states, always OKAY
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_q        <= 1'b0;
			addr_q      <= 8'h00;
			hrdata_o    <= 32'h0;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
		else
		begin
			wr_q        <= addr_ph & hwrite_i;
			addr_q      <= haddr_i[7:0];
			hrdata_o    <= (addr_ph & ~hwrite_i) ? rd_w : 32'h0;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
	end

	// configuration registers; start/stop are not stored
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_q <= `TSIC_CTRL_RST;
			hour_q <= `TSIC_HOUR_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= {2'b00, hwdata_i[`TSIC_CTRL_PULL_HI:0]};
			if (wr_hour)
				hour_q <= hwdata_i[`TSIC_HOUR_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// session state machine: on at the resync hour or by software
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_q <= TSIC_IDLE;
		else
		begin
			case (state_q)
				TSIC_IDLE:
					if (day_start | sw_start)
						state_q <= TSIC_ANALYSE;
				TSIC_ANALYSE:
					if (sw_stop | sess_end)
						state_q <= TSIC_IDLE;
				default:
					state_q <= TSIC_IDLE;
			endcase
		end
	end

	// once per day: rearmed only after the hour has passed
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			done_today_q <= 1'b0;
		else if (day_start)
			done_today_q <= 1'b1;
		else if (!hour_hit)
			done_today_q <= 1'b0;
	end

	// session length in windows; a frame needs about a minute
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			sess_q <= 8'h00;
		else if (!analysing)
			sess_q <= `TSIC_SESSION_WIN;
		else if (win_end)
			sess_q <= sess_q - 8'h01;
	end

	// receiver enable: active only while analysing, polarity selectable
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			receiver_power_enable_o <= 1'b0;
		else
			receiver_power_enable_o <= ~(analysing ^ pwr_pol);
	end

	////////////////////////////////////////////////////////////////////////
	// input sampling and window statistics
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			in_q        <= 1'b0;
			win_q       <= 32'h0;
			hi_q        <= 32'h0;
			edge_seen_q <= 1'b0;
		end
		else
		begin
			in_q <= pulse_in_i;
			if (!analysing || win_end)
			begin
				win_q       <= 32'h0;
				hi_q        <= 32'h0;
				edge_seen_q <= 1'b0;
			end
			else
			begin
				win_q       <= win_q + 32'h1;
				hi_q        <= hi_q + {31'h0, pulse_in_i};
				edge_seen_q <= edge_seen_q | (pulse_in_i ^ in_q);
			end
		end
	end

	// auto detection at each window end
	// pulses fill at most a fifth of a second, so the majority level is idle
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			auto_inv_q  <= 1'b0;
			auto_pull_q <= 1'b0;
		end
		else if (win_end)
		begin
			auto_inv_q <= (hi_q > {1'b0, WIN_CYC[31:1]});
			// a floating open-drain line shows no edges: try the other setting
			if (!edge_seen_q)
				auto_pull_q <= ~auto_pull_q;
		end
	end

	// pull-up drive
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pullup_en_o <= 1'b0;
		else
			pullup_en_o <= pull_use;
	end

	////////////////////////////////////////////////////////////////////////
	// active pulse length; saturates so a stuck line cannot wrap
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			len_q <= 32'h0;
		else if (!analysing || !act)
			len_q <= 32'h0;
		else if (len_q != 32'hffffffff)
			len_q <= len_q + 32'h1;
	end

	// classified bit outputs and counters
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			bit_strobe_o <= 1'b0;
			bit_value_o  <= 1'b0;
			last_bit_q   <= 1'b0;
			bitcnt_q     <= 16'h0;
		end
		else
		begin
			bit_strobe_o <= bit_ok;
			if (bit_ok)
			begin
				bit_value_o <= bit_val;
				last_bit_q  <= bit_val;
				bitcnt_q    <= bitcnt_q + 16'h1;
			end
		end
	end

	// sticky flag: a new bit wins over a software clear
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			seen_q <= 1'b0;
		else if (bit_ok)
			seen_q <= 1'b1;
		else if (wr_stat && hwdata_i[`TSIC_ST_SEEN])
			seen_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_PWR_ON: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(analysing) |=> (receiver_power_enable_o == pwr_pol))
		else $error("enable not asserted at session start");
	AST_PWR_POL: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$changed(pwr_pol) && $stable(analysing) && !wr_ctrl
		|=> (receiver_power_enable_o ^ $past(receiver_power_enable_o)))
		else $error("enable level did not follow polarity");
	AST_INV_FIX: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		inv_mode == `TSIC_INV_INVERT |-> status_w[`TSIC_ST_INV])
		else $error("fixed inversion ignored");
	AST_PULL_FIX: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		pull_mode == `TSIC_PULL_OFF ##1 pull_mode == `TSIC_PULL_OFF |-> !pullup_en_o)
		else $error("pull-up on while forced off");
	AST_PWR_OFF: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!analysing ##1 !analysing |-> (receiver_power_enable_o == !$past(pwr_pol)))
		else $error("receiver enabled while idle");
	AST_DAY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!analysing && hour_hit && !done_today_q |=> analysing && done_today_q)
		else $error("daily resync not started");
	AST_BIT_ONE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bit_ok && len_q >= SPLIT_CYC |=> bit_strobe_o && bit_value_o)
		else $error("long pulse not classed as one");
	AST_BIT_LEN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bit_strobe_o |-> $past(len_q) >= MIN_CYC && $past(len_q) <= MAX_CYC)
		else $error("bit from out-of-range pulse");

	COV_DAY: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		day_start ##1 analysing);
	COV_ZERO: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bit_strobe_o && !bit_value_o);
	COV_ONE: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bit_strobe_o && bit_value_o);

endmodule

// ### testbench/time_signal_input_control_bench.sv
// bench: bus tasks, receiver model, random bits and corner cases
// assumes one master on the register bus and a scaled timing set
`timescale 1ns/1ps
`include "tsic_cfg.svh"
module time_signal_input_control_bench;
	localparam int WIN = 100; // scaled one-second window
	logic        clk = 0, rst_n = 0;
	logic        hsel, hwrite, hready, hresp, pwr_en, pull_en, bstb, bval, line;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [4:0]  cur_hour;
	logic        pol_high, inv, nbit, sent, sent_bit, chk_bits;
	logic        bq[$]; // bits sent, not yet classified
	int          bad_count, check_count, nbits, nstb, h;
	always #2.5 clk = ~clk;
	tsic_top #(.MIN_CYC(5), .SPLIT_CYC(15), .MAX_CYC(25), .WIN_CYC(WIN)) dut
	(
		.clk_sys_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.pulse_in_i(line), .cur_hour_i(cur_hour), .receiver_power_enable_o(pwr_en),
		.pullup_en_o(pull_en), .bit_strobe_o(bstb), .bit_value_o(bval)
	);
	tsic_rx_model #(.WIN(WIN)) rx
	(
		.clk_i(clk), .rst_n_i(rst_n), .power_i(pwr_en), .pol_high_i(pol_high),
		.invert_i(inv), .pullup_i(pull_en), .next_bit_i(nbit), .line_o(line),
		.sent_o(sent), .sent_bit_o(sent_bit)
	);
	////////////////////////////////////////////////////////////////////////
	// compare one value, count it, report a mismatch
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// pin level expected for a session state
	function automatic logic en_level(input logic pol, input logic on);
		return on ? pol : ~pol;
	endfunction
	// one single transfer; waits for ready, no fixed latency assumed
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	// enable pin settles within a few cycles of a session change
	task automatic see_pwr(input logic exp);
		for (int i = 0; i < 8 && pwr_en !== exp; i++) @(posedge clk);
		chk({31'h0, pwr_en}, {31'h0, exp});
	endtask
	task automatic conclude;
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// random bit source and classification check
	always @(posedge clk)
	begin
		nbit <= 1'($urandom_range(1, 0));
		// every strobe the design gives, for the bit counter check
		if (bstb === 1'b1)
			nstb++;
		if (sent && chk_bits)
			bq.push_back(sent_bit);
		if (bstb && chk_bits && bq.size() > 0)
		begin
			nbits++;
			chk({31'h0, bval}, {31'h0, bq.pop_front()});
		end
	end
	// watchdog: far beyond the few thousand cycles the sequence needs
	initial
	begin
		#(20000 * 5);
		bad_count++;
		conclude;
	end
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0; nstb = 0;
		cur_hour = 5'h10; pol_high = 1; inv = 0; chk_bits = 0;
		bad_count = 0; check_count = 0; nbits = 0;
		void'($urandom(32'hbfd93d7b));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({31'h0, pwr_en}, {31'h0, en_level(1'b1, 1'b0)});
		ahb(`TSIC_OFF_CTRL, 1'b0, 32'h0, rd);
		chk(rd, 32'h1);
		ahb(`TSIC_OFF_HOUR, 1'b0, 32'h0, rd);
		chk(rd, 32'h3);
		ahb(8'h10, 1'b0, 32'h0, rd);
		chk(rd, 32'h0);
		// fixed normal input, pull-up forced on, manual start
		ahb(`TSIC_OFF_CTRL, 1'b1, 32'h2b, rd);
		see_pwr(en_level(1'b1, 1'b1));
		chk({31'h0, pull_en}, 32'h1);
		chk_bits = 1;
		repeat (12 * WIN) @(posedge clk);
		ahb(`TSIC_OFF_STATUS, 1'b0, 32'h0, rd);
		chk({31'h0, rd[0]}, 32'h1);
		ahb(`TSIC_OFF_CTRL, 1'b1, 32'h4b, rd);
		chk_bits = 0;
		bq.delete();
		see_pwr(en_level(1'b1, 1'b0));
		// pull-up forced off
		ahb(`TSIC_OFF_CTRL, 1'b1, 32'h13, rd);
		repeat (2) @(posedge clk);
		chk({31'h0, pull_en}, 32'h0);
		// low-active enable, inverted receiver, automatic inversion
		pol_high <= 1'b0;
		ahb(`TSIC_OFF_CTRL, 1'b1, 32'h00, rd);
		see_pwr(en_level(1'b0, 1'b0));
		inv <= 1'b1;
		ahb(`TSIC_OFF_CTRL, 1'b1, 32'h20, rd);
		see_pwr(en_level(1'b0, 1'b1));
		repeat (4 * WIN) @(posedge clk);
		ahb(`TSIC_OFF_STATUS, 1'b0, 32'h0, rd);
		chk({31'h0, rd[1]}, 32'h1);
		chk_bits = 1;
		repeat (8 * WIN) @(posedge clk);
		ahb(`TSIC_OFF_CTRL, 1'b1, 32'h40, rd);
		chk_bits = 0;
		bq.delete();
		see_pwr(en_level(1'b0, 1'b0));
		// daily resync at a random programmed hour
		// skip the idle hour the bench already drives, or the session starts early
		h = $urandom_range(22, 0);
		if (h >= 16)
			h++;
		ahb(`TSIC_OFF_HOUR, 1'b1, 32'(h), rd);
		pol_high <= 1'b1;
		inv <= 1'b0;
		ahb(`TSIC_OFF_CTRL, 1'b1, 32'h03, rd);
		see_pwr(en_level(1'b1, 1'b0));
		cur_hour <= 5'(h);
		see_pwr(en_level(1'b1, 1'b1));
		ahb(`TSIC_OFF_CTRL, 1'b1, 32'h43, rd);
		see_pwr(en_level(1'b1, 1'b0));
		chk({31'h0, nbits > 10}, 32'h1);
		// bit counter and sticky flag, then a software clear of the flag
		ahb(`TSIC_OFF_BITCNT, 1'b0, 32'h0, rd);
		chk(rd, {16'h0, nstb[15:0]});
		ahb(`TSIC_OFF_STATUS, 1'b0, 32'h0, rd);
		chk({31'h0, rd[4]}, 32'h1);
		ahb(`TSIC_OFF_STATUS, 1'b1, 32'h10, rd);
		ahb(`TSIC_OFF_STATUS, 1'b0, 32'h0, rd);
		chk({31'h0, rd[4]}, 32'h0);
		conclude;
	end
endmodule

// ### testbench/tsic_rx_model.sv
// receiver model: one active pulse per window while powered
// assumes the bench states the enable polarity and the output inversion
`timescale 1ns/1ps
module tsic_rx_model #(parameter int WIN = 100)
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic power_i,    // raw enable pin from the device
	input  wire logic pol_high_i, // active level of that pin
	input  wire logic invert_i,   // receiver output inverted
	input  wire logic pullup_i,   // device pull-up switched on
	input  wire logic next_bit_i, // bit for the next pulse
	output logic      line_o,     // demodulated output
	output logic      sent_o,     // a pulse starts this cycle
	output logic      sent_bit_o  // bit of that pulse
);
	int   cnt_q; // position in the one-second window
	logic bit_q; // bit being sent
	wire  on  = (power_i == pol_high_i);
	wire  act = (cnt_q < (bit_q ? WIN / 5 : WIN / 10));
	assign sent_o = on && (cnt_q == 0);
	assign sent_bit_o = bit_q;
	////////////////////////////////////////////////////////////////////////
	// window counter; starts mid-window so the first pulse is whole
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q  <= WIN / 2;
			bit_q  <= 1'b0;
			line_o <= 1'b0;
		end
		else if (!on)
		begin
			cnt_q  <= WIN / 2;
			line_o <= pullup_i ? 1'b1 : ~line_o; // released, no stale level
		end
		else
		begin
			cnt_q  <= (cnt_q == WIN - 1) ? 0 : cnt_q + 1;
			bit_q  <= (cnt_q == WIN - 1) ? next_bit_i : bit_q;
			line_o <= invert_i ^ act;
		end
	end
endmodule
